// ### core/tuner_io_pkg.sv
// Constants, opcodes and register map for the tuner I/O and status decoder
package tuner_io_pkg;

	// APB register byte offsets
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_PC    = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_MEM   = 8'h0C;

	// Instruction field positions
	localparam int OPC_LSB = 10;
	localparam int DH_LSB  = 8;
	localparam int DL_LSB  = 4;
	localparam int LO_LSB  = 0;

	// Six-bit opcodes of the instructions handled here
	localparam logic [5:0] OPC_NOP        = 6'h00;
	localparam logic [5:0] OPC_CNT_SETUP  = 6'h02;
	localparam logic [5:0] OPC_CNT_CTRL   = 6'h03;
	localparam logic [5:0] OPC_FDIR       = 6'h04;
	localparam logic [5:0] OPC_CKSTOP     = 6'h05;
	localparam logic [5:0] OPC_DAC        = 6'h06;
	localparam logic [5:0] OPC_DISP_RAW   = 6'h30;
	localparam logic [5:0] OPC_DISP_DEC   = 6'h31;
	localparam logic [5:0] OPC_BANK       = 6'h33;
	localparam logic [5:0] OPC_SBIT_ZERO  = 6'h34;
	localparam logic [5:0] OPC_SBIT_ONE   = 6'h35;
	localparam logic [5:0] OPC_STAT_CLR   = 6'h36;
	localparam logic [5:0] OPC_STAT_SET   = 6'h37;
	localparam logic [5:0] OPC_PORT_SET   = 6'h38;
	localparam logic [5:0] OPC_PORT_CLR   = 6'h39;
	localparam logic [5:0] OPC_PORT_IN    = 6'h3A;
	localparam logic [5:0] OPC_PORT_OUT   = 6'h3B;
	localparam logic [5:0] OPC_PTST_ONE   = 6'h3C;
	localparam logic [5:0] OPC_PTST_ZERO  = 6'h3D;

	// Port numbers and which of them hold output latches
	localparam logic [3:0]  PORT_A        = 4'h0;
	localparam logic [3:0]  PORT_B        = 4'h1;
	localparam logic [3:0]  PORT_C        = 4'h2;
	localparam logic [3:0]  PORT_D        = 4'h3;
	localparam logic [3:0]  PORT_F        = 4'h4;
	localparam logic [15:0] OUT_PORT_MASK = 16'h3F1C;
	localparam int          SEG_PORT_LSB  = 8;

	// Status bit that acts as the hold enable flag
	localparam int HOLD_EN_BIT = 3;

	// Display geometry
	localparam int NUM_DIGITS = 4;
	localparam int SEG_COUNT  = 23;

	// Reset values
	localparam logic [3:0]  RST_NIBBLE = 4'h0;
	localparam logic [11:0] RST_PC     = 12'h000;

	// Instruction cycle choices, in ns, and clock period
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC0_NS       = 2670;
	localparam int CYC1_NS       = 13330;
	localparam int CYC2_NS       = 40000;
	localparam int CYC0_CLKS     = CYC0_NS / CLK_PERIOD_NS;
	localparam int CYC1_CLKS     = CYC1_NS / CLK_PERIOD_NS;
	localparam int CYC2_CLKS     = CYC2_NS / CLK_PERIOD_NS;

endpackage : tuner_io_pkg

// ### core/data_ram.sv
// Data memory of 256 nibbles with registered read data
`timescale 1ns/100ps
module data_ram (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [7:0] waddr,
	input  wire logic [3:0] wdata,
	input  wire logic [7:0] raddr,
	output logic      [3:0] rdata_q
);

	logic [3:0] mem [256];

	// Synchronous write, registered read (old data on a same-address collision)
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end

endmodule : data_ram

// ### core/seg_pla.sv
// Fixed nibble to seven-segment pattern array, segments g..a in bits 6..0
`timescale 1ns/100ps
module seg_pla (
	input  wire logic [3:0] nibble,
	output logic      [6:0] pattern
);

	// Hexadecimal glyph table
	always_comb begin
		unique case (nibble)
			4'h0: pattern = 7'h3F;
			4'h1: pattern = 7'h06;
			4'h2: pattern = 7'h5B;
			4'h3: pattern = 7'h4F;
			4'h4: pattern = 7'h66;
			4'h5: pattern = 7'h6D;
			4'h6: pattern = 7'h7D;
			4'h7: pattern = 7'h07;
			4'h8: pattern = 7'h7F;
			4'h9: pattern = 7'h6F;
			4'hA: pattern = 7'h77;
			4'hB: pattern = 7'h7C;
			4'hC: pattern = 7'h39;
			4'hD: pattern = 7'h5E;
			4'hE: pattern = 7'h79;
			4'hF: pattern = 7'h71;
		endcase
	end

endmodule : seg_pla

// ### core/tuner_mcu_io_status_decode.sv
// I/O, status, display and clock-stop instruction execution behind an APB slave
// Functional notes
// - Set-status sets selected first status bits
// - Clear-status clears selected first status bits
// - Skip when all selected second-status bits one
// - Skip when all selected second-status bits zero
// - Bank select loads bank register
// - Raw display load copies memory to display_index_a
// - Decoded display load writes seven-segment pattern
// - Port input writes port value to memory
// - Port output copies memory to port latch
// - Port bit set forces masked bits one
// - Port bit clear forces masked bits zero
// - Port test skips when masked bits one
// - Port test skips when masked bits zero
// - Counter setup loads control word a
// - Counter control loads control word b
// - Direction load sets port F outputs
// - Clock stop acts only with hold pin low
// - Converter load writes immediate to converter registers
// - Instruction cycle time is a build choice
// - Each segment pin built as display or port
// - Hold mode needs pin low and enable flag
// - Standby only entered from hold mode
`timescale 1ns/100ps
module tuner_mcu_io_status_decode
	import tuner_io_pkg::*;
#(
	parameter int                   CYCLE_SEL   = 0,
	parameter logic [SEG_COUNT-1:0] SEG_GP_MASK = 23'h000000
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 hold_req_n,
	input  wire logic [3:0]           status2_in,
	input  wire logic [3:0]           port_a_in,
	input  wire logic [3:0]           port_b_in,
	input  wire logic [3:0]           port_f_i,
	output logic      [3:0]           port_f_o,
	output logic      [3:0]           port_f_oe,
	output logic      [3:0]           port_c_out,
	output logic      [3:0]           port_d_out,
	output logic      [SEG_COUNT-1:0] segment_outputs,
	output logic      [3:0]           counter_control_word_a,
	output logic      [3:0]           counter_control_word_b,
	output logic      [7:0]           dac0_out,
	output logic      [7:0]           dac1_out,
	output logic      [1:0]           bank_sel,
	output logic                      hold_mode,
	output logic                      standby
);

	////////////////////////////////////////////////////////////////////////////
	// State

	// Instruction cycle length picked at build time
	localparam int CYC_CLKS = (CYCLE_SEL == 2) ? CYC2_CLKS :
	                          (CYCLE_SEL == 1) ? CYC1_CLKS : CYC0_CLKS;
	localparam logic [11:0] CYC_LAST = 12'(CYC_CLKS - 1);

	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_EXEC, S_MRD} fsm_t;

	typedef struct packed {
		fsm_t                        st;
		logic [15:0]                 instr;
		logic [11:0]                 pc;
		logic                        skip;
		logic [3:0]                  stat1;
		logic [1:0]                  bank;
		logic [3:0]                  ucw_a;
		logic [3:0]                  ucw_b;
		logic [7:0]                  dac0;
		logic [7:0]                  dac1;
		logic [3:0]                  fdir;
		logic [15:0][3:0]            olat;
		logic [NUM_DIGITS-1:0][6:0]  display_index_a;
		logic [SEG_COUNT-1:0]        seg;
		logic                        hold_mode;
		logic                        standby;
		logic [11:0]                 tick_cnt;
		logic [7:0]                  mem_ptr;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
		logic [3:0]                  pa1;
		logic [3:0]                  pa2;
		logic [3:0]                  pb1;
		logic [3:0]                  pb2;
		logic [3:0]                  pf1;
		logic [3:0]                  pf2;
		logic [3:0]                  s21;
		logic [3:0]                  s22;
		logic                        hold1;
		logic                        hold2;
	} state_t;

	state_t q;
	state_t d;

	logic       ram_we;
	logic [7:0] ram_waddr;
	logic [3:0] ram_wdata;
	logic [7:0] ram_raddr;
	logic [3:0] ram_rdata;
	logic [6:0] pla_pattern;

	////////////////////////////////////////////////////////////////////////////
	// Instruction fields and helpers

	logic [5:0] opc;
	logic [1:0] dh;
	logic [3:0] dl;
	logic [3:0] lo;
	logic [7:0] mem_addr;
	logic [3:0] port_val;
	logic [3:0] lat_dl;
	logic       access;
	logic       tick;

	assign opc      = q.instr[OPC_LSB +: 6];
	assign dh       = q.instr[DH_LSB +: 2];
	assign dl       = q.instr[DL_LSB +: 4];
	assign lo       = q.instr[LO_LSB +: 4];
	assign mem_addr = {q.bank, dh, dl};
	assign access   = psel && penable && !q.pready;
	assign tick     = (q.tick_cnt == 12'h000);

	// Port number field differs: IN/OUT carry it low, bit ops carry it in dl
	assign lat_dl = (opc == OPC_PORT_IN || opc == OPC_PORT_OUT) ? lo : dl;

	// Value seen on a port number; port F mixes latch and pin by direction
	always_comb begin
		port_val = 4'h0;
		if (lat_dl == PORT_A) begin
			port_val = q.pa2;
		end else if (lat_dl == PORT_B) begin
			port_val = q.pb2;
		end else if (lat_dl == PORT_F) begin
			port_val = (q.fdir & q.olat[PORT_F]) | (~q.fdir & q.pf2);
		end else if (OUT_PORT_MASK[lat_dl]) begin
			port_val = q.olat[lat_dl];
		end
	end

	// Memory read address: software pointer when idle or in a memory read, operand otherwise
	assign ram_raddr = (q.st == S_IDLE || q.st == S_MRD) ? q.mem_ptr : mem_addr;

	data_ram u_ram (
		.clk     (pclk),
		.we      (ram_we),
		.waddr   (ram_waddr),
		.wdata   (ram_wdata),
		.raddr   (ram_raddr),
		.rdata_q (ram_rdata)
	);

	seg_pla u_pla (
		.nibble  (ram_rdata),
		.pattern (pla_pattern)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d         = q;
		ram_we    = 1'b0;
		ram_waddr = q.mem_ptr;
		ram_wdata = 4'h0;
		d.pready  = 1'b0;
		d.pslverr = 1'b0;

		// Two-flop synchronisers for pins
		d.pa1   = port_a_in;
		d.pa2   = q.pa1;
		d.pb1   = port_b_in;
		d.pb2   = q.pb1;
		d.pf1   = port_f_i;
		d.pf2   = q.pf1;
		d.s21   = status2_in;
		d.s22   = q.s21;
		d.hold1 = hold_req_n;
		d.hold2 = q.hold1;

		// Hold mode follows pin and enable flag; releasing the pin wakes standby
		d.hold_mode = q.stat1[HOLD_EN_BIT] && !q.hold2;
		if (q.hold2) begin
			d.standby = 1'b0;
		end

		// Instruction cycle timer, frozen while the clock is stopped
		if (!q.standby) begin
			d.tick_cnt = tick ? CYC_LAST : q.tick_cnt - 12'h001;
		end

		// Segment pins pick display latch or general purpose latch per bit
		for (int i = 0; i < SEG_COUNT; i++) begin
			d.seg[i] = SEG_GP_MASK[i] ? q.olat[SEG_PORT_LSB + i / 4][i % 4]
			                          : q.display_index_a[i / 7][i % 7];
		end

		unique case (q.st)
			// Register accesses
			S_IDLE: begin
				if (access) begin
					d.prdata = 32'h0000_0000;
					if (paddr == REG_INSTR) begin
						if (pwrite) begin
							d.instr = pwdata[15:0];
							d.st    = S_WAIT;
						end else begin
							d.prdata[15:0] = q.instr;
							d.pready       = 1'b1;
						end
					end else if (paddr == REG_PC) begin
						d.prdata[11:0] = q.pc;
						d.pready       = 1'b1;
					end else if (paddr == REG_STATE) begin
						d.prdata[12:0] = {q.s22, q.standby, q.hold_mode, q.skip,
						                  q.bank, q.stat1};
						d.pready       = 1'b1;
					end else if (paddr == REG_MEM) begin
						if (pwrite) begin
							d.mem_ptr = pwdata[11:4];
							ram_we    = 1'b1;
							ram_waddr = pwdata[11:4];
							ram_wdata = pwdata[3:0];
							d.pready  = 1'b1;
						end else begin
							d.st = S_MRD;
						end
					end else begin
						d.pslverr = 1'b1;
						d.pready  = 1'b1;
					end
				end
			end

			// Hold the bus until the next instruction cycle boundary
			S_WAIT: begin
				if (tick && !q.standby) begin
					d.st = S_EXEC;
				end
			end

			S_MRD: begin
				d.prdata = {20'h00000, q.mem_ptr, ram_rdata};
				d.pready = 1'b1;
				d.st     = S_IDLE;
			end

			// Execute one instruction, memory operand already in ram_rdata
			S_EXEC: begin
				d.pc     = q.pc + 12'h001;
				d.pready = 1'b1;
				d.st     = S_IDLE;
				if (q.skip) begin
					d.skip = 1'b0;
				end else begin
					unique case (opc)
						OPC_STAT_SET: d.stat1 = q.stat1 | lo;
						OPC_STAT_CLR: d.stat1 = q.stat1 & ~lo;
						OPC_SBIT_ONE:  d.skip = ((q.s22 & lo) == lo);
						OPC_SBIT_ZERO: d.skip = ((q.s22 & lo) == 4'h0);
						OPC_BANK:     d.bank = lo[1:0];
						OPC_DISP_RAW: begin
							if (lo < 4'(NUM_DIGITS)) begin
								d.display_index_a[lo[1:0]] = {3'h0, ram_rdata};
							end
						end
						OPC_DISP_DEC: begin
							if (lo < 4'(NUM_DIGITS)) begin
								d.display_index_a[lo[1:0]] = pla_pattern;
							end
						end
						OPC_PORT_IN: begin
							ram_we    = 1'b1;
							ram_waddr = mem_addr;
							ram_wdata = port_val;
						end
						OPC_PORT_OUT: begin
							if (OUT_PORT_MASK[lo]) begin
								d.olat[lo] = ram_rdata;
							end
						end
						OPC_PORT_SET: begin
							if (OUT_PORT_MASK[dl]) begin
								d.olat[dl] = q.olat[dl] | lo;
							end
						end
						OPC_PORT_CLR: begin
							if (OUT_PORT_MASK[dl]) begin
								d.olat[dl] = q.olat[dl] & ~lo;
							end
						end
						OPC_PTST_ONE:  d.skip = ((port_val & lo) == lo);
						OPC_PTST_ZERO: d.skip = ((port_val & lo) == 4'h0);
						OPC_CNT_SETUP: d.ucw_a = lo;
						OPC_CNT_CTRL:  d.ucw_b = lo;
						OPC_FDIR:      d.fdir = lo;
						OPC_CKSTOP: begin
							if (!q.hold2 && q.hold_mode) begin
								d.standby = 1'b1;
							end
						end
						OPC_DAC: begin
							if (q.instr[8]) begin
								d.dac1 = q.instr[7:0];
							end else begin
								d.dac0 = q.instr[7:0];
							end
						end
						default: begin
						end
					endcase
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q          <= '0;
			q.st       <= S_IDLE;
			q.pc       <= RST_PC;
			q.stat1    <= RST_NIBBLE;
			q.tick_cnt <= CYC_LAST;
			q.hold1    <= 1'b1;
			q.hold2    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign prdata                 = q.prdata;
	assign pready                 = q.pready;
	assign pslverr                = q.pslverr;
	assign port_f_o               = q.olat[PORT_F];
	assign port_f_oe              = q.fdir;
	assign port_c_out             = q.olat[PORT_C];
	assign port_d_out             = q.olat[PORT_D];
	assign segment_outputs        = q.seg;
	assign counter_control_word_a = q.ucw_a;
	assign counter_control_word_b = q.ucw_b;
	assign dac0_out               = q.dac0;
	assign dac1_out               = q.dac1;
	assign bank_sel               = q.bank;
	assign hold_mode              = q.hold_mode;
	assign standby                = q.standby;

endmodule : tuner_mcu_io_status_decode

// ### verif/tuner_io_checker.sv
// Concurrent checks on the ports of the tuner I/O and status decoder
`timescale 1ns/100ps
module tuner_io_checker
	import tuner_io_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 hold_req_n,
	input wire logic [3:0]           port_f_oe,
	input wire logic [3:0]           port_c_out,
	input wire logic [3:0]           port_d_out,
	input wire logic [SEG_COUNT-1:0] segment_outputs,
	input wire logic [3:0]           counter_control_word_a,
	input wire logic [3:0]           counter_control_word_b,
	input wire logic [7:0]           dac0_out,
	input wire logic [7:0]           dac1_out,
	input wire logic [1:0]           bank_sel,
	input wire logic                 hold_mode,
	input wire logic                 standby
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer shape
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready idle");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
	a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");

	////////////////////////////////////////////////////////////////////////////////
	// Latches move only when an instruction completes
	a_port_on_exec: assert property ($changed({port_c_out, port_d_out, port_f_oe})
		|-> ##[0:1] pready) else $error("port latch moved without instruction");
	a_words_on_exec: assert property ($changed({counter_control_word_a,
		counter_control_word_b, dac0_out, dac1_out, bank_sel}) |-> ##[0:1] pready)
		else $error("word moved without instruction");
	a_seg_on_exec: assert property ($changed(segment_outputs) |-> $past(pready))
		else $error("segments moved without instruction");

	////////////////////////////////////////////////////////////////////////////////
	// Hold and standby
	a_hold_pin_high: assert property (hold_req_n [*5] |-> !hold_mode)
		else $error("hold mode with pin high");
	a_standby_in_hold: assert property (standby |-> hold_mode)
		else $error("standby outside hold");
	a_standby_pin: assert property ($rose(standby) |-> !$past(hold_req_n, 3)
		##[0:1] pready) else $error("standby without low pin");
	a_standby_exit: assert property (hold_req_n [*5] |-> !standby)
		else $error("standby kept with pin high");
endmodule : tuner_io_checker

bind tuner_mcu_io_status_decode tuner_io_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.hold_req_n(hold_req_n), .port_f_oe(port_f_oe), .port_c_out(port_c_out),
	.port_d_out(port_d_out), .segment_outputs(segment_outputs),
	.counter_control_word_a(counter_control_word_a),
	.counter_control_word_b(counter_control_word_b), .dac0_out(dac0_out),
	.dac1_out(dac1_out), .bank_sel(bank_sel), .hold_mode(hold_mode), .standby(standby));

// ### verif/tuner_mcu_io_status_decode_tb.sv
// Self-checking bench for the tuner I/O and status decoder
`timescale 1ns/100ps
module tuner_mcu_io_status_decode_tb;
	import tuner_io_pkg::*;
	localparam logic [6:0] GLYPH [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
		7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	localparam logic [3:0] MSK [8] = '{4'hA, 4'hB, 4'h5, 4'h7, 4'h6, 4'h7, 4'h9, 4'hB};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic hold_req_n = 1'b1, pready, pslverr, hold_mode, standby, serr;
	logic [7:0] paddr = 8'h00, dac0_out, dac1_out;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h4A;
	logic [3:0] status2_in = 4'hA, port_a_in = 4'h0, port_b_in = 4'h0, port_f_i = 4'h0;
	logic [3:0] port_f_o, port_f_oe, port_c_out, port_d_out, cw_a, cw_b, st, cc, dd, v, dg;
	logic [1:0] bank_sel;
	logic [SEG_COUNT-1:0] segment_outputs;
	logic [11:0] pc_exp = 12'h000;
	int err_count = 0, samples_checked = 0;

	tuner_mcu_io_status_decode #(.CYCLE_SEL(0)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hold_req_n(hold_req_n),
		.status2_in(status2_in), .port_a_in(port_a_in), .port_b_in(port_b_in),
		.port_f_i(port_f_i), .port_f_o(port_f_o), .port_f_oe(port_f_oe),
		.port_c_out(port_c_out), .port_d_out(port_d_out), .segment_outputs(segment_outputs),
		.counter_control_word_a(cw_a), .counter_control_word_b(cw_b), .dac0_out(dac0_out),
		.dac1_out(dac1_out), .bank_sel(bank_sel), .hold_mode(hold_mode), .standby(standby));

	// Clock
	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [3:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[3:0];
	endfunction : rnd

	function automatic logic [15:0] ins(logic [5:0] o, logic [1:0] h, logic [3:0] l, logic [3:0] z);
		return {o, h, l, z};
	endfunction : ins

	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, s, g, e);
		end
	endtask : chk

	// One APB transfer; answer taken at the rising edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (n >= 5000) begin
				err_count++;
				print_verdict();
			end
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : apb

	task automatic exec(input logic [15:0] w);
		apb(1'b1, REG_INSTR, {16'h0, w});
		pc_exp++;
	endtask : exec

	task automatic pin(input logic l);
		@(posedge pclk);
		hold_req_n <= l;
		repeat (6) @(negedge pclk);
	endtask : pin

	// Watchdog
	initial begin
		#600000;
		err_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		apb(1'b1, REG_PC, 32'hFFF);
		apb(1'b0, REG_PC, 32'h0);
		chk(rd, 32'h0, "pc reset");
		apb(1'b0, 8'h10, 32'h0);
		chk({serr, rd}, {1'b1, 32'h0}, "unmapped");
		st = 4'h0;
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			st = i[0] ? st & ~v : st | v;
			exec(ins(i[0] ? OPC_STAT_CLR : OPC_STAT_SET, 2'h0, 4'h0, v));
			apb(1'b0, REG_STATE, 32'h0);
			chk(rd[3:0], st, "status1");
		end
		for (int b = 0; b < 4; b++) begin
			exec(ins(OPC_BANK, 2'h0, 4'h0, b[3:0]));
			chk(bank_sel, b[1:0], "bank");
		end
		for (int j = 0; j < 2; j++) begin
			v = rnd();
			exec(ins(OPC_CNT_SETUP, 2'h0, 4'h0, v));
			chk(cw_a, v, "word a");
			exec(ins(OPC_CNT_CTRL, 2'h0, 4'h0, {~v}));
			chk(cw_b, {~v}, "word b");
			exec(ins(OPC_FDIR, 2'h0, 4'h0, v));
			chk(port_f_oe, v, "direction");
			exec(ins(OPC_DAC, j[1:0], v, {~v}));
			chk(j ? dac1_out : dac0_out, {v, ~v}, "dac");
		end
		cc = 4'h0;
		dd = 4'h0;
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			exec(ins(i[0] ? OPC_PORT_CLR : OPC_PORT_SET, 2'h0, i[1] ? PORT_D : PORT_C, v));
			if (i[1]) dd = i[0] ? dd & ~v : dd | v;
			else cc = i[0] ? cc & ~v : cc | v;
			chk({port_c_out, port_d_out}, {cc, dd}, "port bits");
		end
		v = rnd();
		apb(1'b1, REG_MEM, {20'h0, 8'hC5, v});
		exec(ins(OPC_PORT_OUT, 2'h0, 4'h5, PORT_D));
		chk(port_d_out, v, "port out");
		for (int p = 0; p < 2; p++) begin
			v = rnd();
			@(posedge pclk);
			if (p == 1) port_b_in <= v;
			else port_a_in <= v;
			repeat (4) @(negedge pclk);
			exec(ins(OPC_PORT_IN, 2'h0, 4'h5, p[3:0]));
			apb(1'b0, REG_MEM, 32'h0);
			chk(rd[3:0], v, "port in");
		end
		// Port F: latch where direction is output, pin where it is input
		v = rnd();
		dg = rnd();
		cc = (dg & v) | (~dg & ~v);
		exec(ins(OPC_FDIR, 2'h0, 4'h0, dg));
		exec(ins(OPC_PORT_SET, 2'h0, PORT_F, v));
		chk(port_f_o, v, "port f latch");
		@(posedge pclk);
		port_f_i <= ~v;
		repeat (4) @(negedge pclk);
		exec(ins(OPC_PORT_IN, 2'h0, 4'h5, PORT_F));
		apb(1'b0, REG_MEM, 32'h0);
		chk(rd[3:0], cc, "port f mix");
		for (int n = 0; n < 17; n++) begin
			v = n < 16 ? n[3:0] : rnd();
			dg = 4'(n % 3);
			apb(1'b1, REG_MEM, {20'h0, 8'hC5, v});
			exec(ins(n < 16 ? OPC_DISP_DEC : OPC_DISP_RAW, 2'h0, 4'h5, dg));
			chk(segment_outputs[dg * 7 +: 7], n < 16 ? GLYPH[v] : {3'b000, v}, "display_index_a");
		end
		exec(ins(OPC_PORT_CLR, 2'h0, PORT_C, 4'hF));
		exec(ins(OPC_PORT_SET, 2'h0, PORT_C, 4'h6));
		for (int i = 0; i < 8; i++) begin
			exec(ins(OPC_PORT_CLR, 2'h0, PORT_D, 4'hF));
			exec(ins(i < 2 ? OPC_SBIT_ONE : i < 4 ? OPC_SBIT_ZERO : i < 6 ? OPC_PTST_ONE
				: OPC_PTST_ZERO, 2'h0, i < 4 ? 4'h0 : PORT_C, MSK[i]));
			exec(ins(OPC_PORT_SET, 2'h0, PORT_D, 4'hF));
			chk(port_d_out, i[0] ? 4'hF : 4'h0, "skip");
		end
		apb(1'b0, REG_PC, 32'h0);
		chk(rd[11:0], pc_exp, "pc");
		apb(1'b0, REG_STATE, 32'h0);
		chk(rd[12:4], {status2_in, 3'h0, 2'h3}, "state fields");
		apb(1'b0, REG_INSTR, 32'h0);
		chk(rd[15:0], ins(OPC_PORT_SET, 2'h0, PORT_D, 4'hF), "instr readback");
		exec(ins(OPC_STAT_CLR, 2'h0, 4'h0, 4'h8));
		pin(1'b0);
		chk(hold_mode, 1'b0, "hold no flag");
		exec(ins(OPC_CKSTOP, 2'h0, 4'h0, 4'h0));
		chk(standby, 1'b0, "stop outside hold");
		exec(ins(OPC_STAT_SET, 2'h0, 4'h0, 4'h8));
		repeat (4) @(negedge pclk);
		chk(hold_mode, 1'b1, "hold");
		pin(1'b1);
		chk(hold_mode, 1'b0, "hold pin high");
		exec(ins(OPC_CKSTOP, 2'h0, 4'h0, 4'h0));
		chk(standby, 1'b0, "stop pin high");
		pin(1'b0);
		exec(ins(OPC_CKSTOP, 2'h0, 4'h0, 4'h0));
		chk(standby, 1'b1, "standby");
		pin(1'b1);
		chk(standby, 1'b0, "standby exit");
		print_verdict();
	end
endmodule : tuner_mcu_io_status_decode_tb
